//--- logic/tsc_config_regs.sv
// Register bank of the 16-channel touch sensor with calibration window timer
// Summary of operation
// - Each threshold register serves two channels: odd in bits 3:0, even in 7:4.
// - Three-bit middle code maps to middle threshold 0.50 to 3.55 percent; reset 011.
// - Range bit 0 selects low table, 0.40 to 2.85 percent.
// - Range bit 1, the reset value, selects high table, 0.6 to 4.30 percent.
// - Speed mode bit 0 gives slow calibration after the window; 1 forces fast.
// - After power-on, calibrate very fast for the first-touch window, then normal.
// - Window field codes give 19, 37, 56, 74 times 16 periods; reset 01.
// - Interrupt level: 00/10 mid or high, 01 low or up, 11 high only.
// - Response period equals response field plus 2; field resets to 011.
// - Touch level 00 none, 01 low, 10 middle, 11 high per channel.
//
// Soft reset is a level that restarts the window.
// Register port is a plain byte port.

module tsc_config_regs
   import tsc_pkg::*;
#(
   parameter int CHANNELS      = 16,     // Sensing channels
   parameter int PERIOD_CYCLES = 100000  // Clock cycles in one internal period
)(
   input  wire logic                    clk,              // 100 MHz clock
   input  wire logic                    rstn,             // Async reset, active low
   input  wire logic [7:0]              reg_addr,         // Register byte address
   input  wire logic                    reg_wr,           // Write strobe, one cycle
   input  wire logic [7:0]              reg_wdata,        // Write data
   input  wire logic                    reg_rd,           // Read strobe, one cycle
   output logic      [7:0]              reg_rdata,        // Read data, next cycle
   input  wire logic [2*CHANNELS-1:0]   touch_level_in,   // Levels from sensing core
   output logic      [2*CHANNELS-1:0]   touch_level_out,  // Registered levels
   output wire logic [9*CHANNELS-1:0]   mid_thresh,       // Middle thresholds
   output wire logic [9*CHANNELS-1:0]   side_thresh,      // Low/high thresholds
   output wire logic                    fast_calib,       // Fast calibration active
   output logic                         first_touch_busy, // First-touch window running
   output wire logic [3:0]              resp_period,      // Response period in periods
   output wire logic                    multi_out_sel,    // Output mode select bit
   output wire logic                    imp_sel,          // Impedance select bit
   output wire logic                    sleep_en,         // Sleep mode enable
   output wire logic                    soft_reset,       // Digital soft reset level
   output wire logic [1:0]              init_bits,        // Config B bits 1:0
   output wire logic [CHANNELS-1:0]     baseline_reload,  // Reference reset per channel
   output wire logic [CHANNELS-1:0]     channel_pause,    // Hold per channel
   output wire logic [CHANNELS-1:0]     calib_freeze,     // Calibration hold per channel
   output wire logic [7:0]              noise_lock,       // Lock mask bits
   output logic                         irq               // Touch interrupt, active high
);

   // Pair count, counter width
   localparam int NPAIR = CHANNELS / 2;
   localparam int PW    = $clog2(PERIOD_CYCLES + 1);
   localparam logic [PW-1:0] PERIOD_LAST = PW'(PERIOD_CYCLES - 1);

   // ==========================================================
   // Storage
   logic [7:0]  sens_q [NPAIR];
   logic [7:0]  cfga_q;
   logic [7:0]  cfgb_q;
   logic [7:0]  reload_lo_q;
   logic [7:0]  reload_hi_q;
   logic [7:0]  pause_lo_q;
   logic [7:0]  pause_hi_q;
   logic [7:0]  freeze_lo_q;
   logic [7:0]  freeze_hi_q;
   logic [7:0]  lock_q;

   // Window timers
   logic [PW-1:0] per_cnt_q;
   logic [10:0] win_cnt_q;

   // ==========================================================
   // Address decode
   // No hit means ignored
   wire logic [NPAIR-1:0] sens_hit;

   wire logic hit_cfga      = (reg_addr == OFS_GENERAL_CFG_A);
   wire logic hit_cfgb      = (reg_addr == OFS_GENERAL_CFG_B);

   wire logic hit_reload_lo = (reg_addr == OFS_RELOAD_CH1_8);
   wire logic hit_reload_hi = (reg_addr == OFS_RELOAD_CH9_16);
   wire logic hit_pause_lo  = (reg_addr == OFS_PAUSE_CH1_8);
   wire logic hit_pause_hi  = (reg_addr == OFS_PAUSE_CH9_16);
   wire logic hit_freeze_lo = (reg_addr == OFS_FREEZE_CH1_8);
   wire logic hit_freeze_hi = (reg_addr == OFS_FREEZE_CH9_16);
   wire logic hit_lock      = (reg_addr == OFS_NOISE_LOCK);

   // Sensitivity offsets are split in two groups, hence the small table
   function automatic logic [7:0] sens_ofs(input int idx);
      logic [7:0] ofs;
      ofs = 8'h00;
      unique case (idx)
         0: ofs = OFS_SENS_CH1_CH2;
         1: ofs = OFS_SENS_CH3_CH4;
         2: ofs = OFS_SENS_CH5_CH6;
         3: ofs = OFS_SENS_CH7_CH8;
         4: ofs = OFS_SENS_CH9_CH10;
         5: ofs = OFS_SENS_CH11_CH12;
         6: ofs = OFS_SENS_CH13_CH14;
         7: ofs = OFS_SENS_CH15_CH16;
         default: ofs = 8'hFF;
      endcase
      return ofs;
   endfunction

   // ==========================================================
   // Threshold registers, one per channel pair
   genvar gp;
   generate
      for (gp = 0; gp < NPAIR; gp++) begin : g_pair
         // Pair offsets are split
         assign sens_hit[gp] = (reg_addr == sens_ofs(gp));

         // Writes store the whole byte; both fields are live
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               sens_q[gp] <= RST_SENS;
            end else if (reg_wr && sens_hit[gp]) begin
               sens_q[gp] <= reg_wdata;
            end
         end

         // Odd channel in low nibble, even channel in high nibble
         tsc_thresh_dec u_odd (
            .mid_thresh_code  (sens_q[gp][ODD_CODE_LSB +: 3]),
            .thresh_range_sel (sens_q[gp][ODD_RANGE_BIT]),
            .mid_thresh       (mid_thresh[9*(2*gp) +: 9]),
            .side_thresh      (side_thresh[9*(2*gp) +: 9])
         );
         tsc_thresh_dec u_even (
            .mid_thresh_code  (sens_q[gp][EVEN_CODE_LSB +: 3]),
            .thresh_range_sel (sens_q[gp][EVEN_RANGE_BIT]),
            .mid_thresh       (mid_thresh[9*(2*gp+1) +: 9]),
            .side_thresh      (side_thresh[9*(2*gp+1) +: 9])
         );
      end
   endgenerate

   // ==========================================================
   // Control registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfga_q <= RST_GENERAL_CFG_A;
         cfgb_q <= RST_GENERAL_CFG_B;
      end else begin
         // All control A bits are live
         if (reg_wr && hit_cfga) cfga_q <= reg_wdata;
         // Reserved bits are masked so they always read zero
         if (reg_wr && hit_cfgb) cfgb_q <= reg_wdata & CFG_B_WMASK;
      end
   end

   // Per-channel hold, reload, freeze and lock bytes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reload_lo_q <= RST_LOW_BANK;
         reload_hi_q <= RST_HIGH_BANK;
         pause_lo_q  <= RST_LOW_BANK;
         pause_hi_q  <= RST_HIGH_BANK;
         freeze_lo_q <= RST_ZERO;
         freeze_hi_q <= RST_ZERO;
         lock_q      <= RST_ZERO;
      end else if (reg_wr) begin
         // Offsets are distinct
         if (hit_reload_lo) reload_lo_q <= reg_wdata;
         if (hit_reload_hi) reload_hi_q <= reg_wdata;
         if (hit_pause_lo)  pause_lo_q  <= reg_wdata;
         if (hit_pause_hi)  pause_hi_q  <= reg_wdata;
         if (hit_freeze_lo) freeze_lo_q <= reg_wdata;
         if (hit_freeze_hi) freeze_hi_q <= reg_wdata;
         if (hit_lock)      lock_q      <= reg_wdata;
      end
   end

   // ==========================================================
   // Field outputs
   // Control A fields
   wire logic       speed_mode = cfga_q[SPEED_MODE_BIT];
   wire logic [1:0] ftw_sel    = cfga_q[FTW_LSB +: 2];
   wire logic [1:0] irq_sel    = cfga_q[IRQ_SEL_LSB +: 2];
   assign resp_period     = {1'b0, cfga_q[RESP_LSB +: 3]} + RESP_OFFSET;

   // Control B fields
   assign multi_out_sel   = cfgb_q[MULTI_BIT];
   assign imp_sel         = cfgb_q[IMP_SEL_BIT];
   assign sleep_en        = cfgb_q[SLEEP_BIT];
   assign soft_reset      = cfgb_q[SOFT_RESET_BIT];
   assign init_bits       = cfgb_q[1:0];

   // Channel 1 sits in bit 0
   assign baseline_reload = CHANNELS'({reload_hi_q, reload_lo_q});
   assign channel_pause   = CHANNELS'({pause_hi_q, pause_lo_q});
   assign calib_freeze    = CHANNELS'({freeze_hi_q, freeze_lo_q});
   assign noise_lock      = lock_q;

   // ==========================================================
   // First-touch window: periods counted from reset release
   // Window length by code
   logic [10:0] ftw_target;
   always_comb begin
      unique case (ftw_sel)
         2'h0: ftw_target = FTW_PERIODS_0;
         2'h1: ftw_target = FTW_PERIODS_1;
         2'h2: ftw_target = FTW_PERIODS_2;
         2'h3: ftw_target = FTW_PERIODS_3;
      endcase
   end

   // Free-running period tick
   wire logic period_tick = (per_cnt_q == PERIOD_LAST);
   // Compare with >= so that shrinking the field mid-window ends it at once
   wire logic window_done = (win_cnt_q >= ftw_target);

   // Soft reset restarts the window just as a power-on would
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         per_cnt_q        <= '0;
         win_cnt_q        <= '0;
         first_touch_busy <= 1'b1;
      end else if (soft_reset) begin
         // Held while the bit is set
         per_cnt_q        <= '0;
         win_cnt_q        <= '0;
         first_touch_busy <= 1'b1;
      end else begin
         per_cnt_q <= period_tick ? '0 : per_cnt_q + PW'(1);
         // Stops with busy, so no wrap
         if (first_touch_busy && period_tick) win_cnt_q <= win_cnt_q + 11'h001;
         if (window_done) first_touch_busy <= 1'b0;
      end
   end

   // Window forces very fast calibration; afterwards the mode bit decides
   assign fast_calib = first_touch_busy | speed_mode;

   // ==========================================================
   // Touch levels and interrupt
   // Per-channel level match
   logic [CHANNELS-1:0] lvl_hit;
   always_comb begin
      for (int c = 0; c < CHANNELS; c++) begin
         // Codes 00 and 10 act alike
         unique case (irq_sel)
            IRQ_ON_LOW:   lvl_hit[c] = (touch_level_out[2*c +: 2] != LVL_NONE);
            IRQ_ON_HIGH:  lvl_hit[c] = (touch_level_out[2*c +: 2] == LVL_HIGH);
            IRQ_ON_MID_A,
            IRQ_ON_MID_B: lvl_hit[c] = (touch_level_out[2*c +: 2] >= LVL_MID);
         endcase
      end
   end

   // Levels are held cleared during soft reset so no stale touch leaks out
   // Irq lags the levels by a cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         touch_level_out <= '0;
         irq             <= 1'b0;
      end else begin
         touch_level_out <= soft_reset ? '0 : touch_level_in;
         irq             <= |lvl_hit;
      end
   end

   // ==========================================================
   // Read path: registered, unmapped addresses return zero
   logic [7:0] rd_mux;
   // Pad keeps the slices legal
   wire logic [2*CHANNELS+31:0] lvl_pad = {32'h0, touch_level_out};
   always_comb begin
      rd_mux = 8'h00;
      // Unmapped reads give zero
      for (int p = 0; p < NPAIR; p++) begin
         if (sens_hit[p]) rd_mux = sens_q[p];
      end
      if (hit_cfga)      rd_mux = cfga_q;
      if (hit_cfgb)      rd_mux = cfgb_q;
      if (hit_reload_lo) rd_mux = reload_lo_q;
      if (hit_reload_hi) rd_mux = reload_hi_q;
      if (hit_pause_lo)  rd_mux = pause_lo_q;
      if (hit_pause_hi)  rd_mux = pause_hi_q;
      if (hit_freeze_lo) rd_mux = freeze_lo_q;
      if (hit_freeze_hi) rd_mux = freeze_hi_q;
      if (hit_lock)      rd_mux = lock_q;
      // Read-only level bytes
      if (reg_addr == OFS_LEVEL_CH1_4)   rd_mux = lvl_pad[7:0];
      if (reg_addr == OFS_LEVEL_CH5_8)   rd_mux = lvl_pad[15:8];
      if (reg_addr == OFS_LEVEL_CH9_12)  rd_mux = lvl_pad[23:16];
      if (reg_addr == OFS_LEVEL_CH13_16) rd_mux = lvl_pad[31:24];
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         // Stands until the next read
         reg_rdata <= rd_mux;
      end
   end

endmodule

//--- logic/tsc_pkg.sv
// Shared constants of the touch sensor configuration register bank
package tsc_pkg;

   // ==========================================================
   // Register offsets (byte addresses of the internal map)
   localparam logic [7:0] OFS_SENS_CH1_CH2    = 8'h02;
   localparam logic [7:0] OFS_SENS_CH3_CH4    = 8'h03;
   localparam logic [7:0] OFS_SENS_CH5_CH6    = 8'h04;
   localparam logic [7:0] OFS_SENS_CH7_CH8    = 8'h05;
   localparam logic [7:0] OFS_SENS_CH9_CH10   = 8'h06;
   localparam logic [7:0] OFS_SENS_CH11_CH12  = 8'h07;
   localparam logic [7:0] OFS_GENERAL_CFG_A   = 8'h08;
   localparam logic [7:0] OFS_GENERAL_CFG_B   = 8'h09;
   localparam logic [7:0] OFS_RELOAD_CH1_8    = 8'h0A;
   localparam logic [7:0] OFS_RELOAD_CH9_16   = 8'h0B;
   localparam logic [7:0] OFS_PAUSE_CH1_8     = 8'h0C;
   localparam logic [7:0] OFS_PAUSE_CH9_16    = 8'h0D;
   localparam logic [7:0] OFS_FREEZE_CH1_8    = 8'h0E;
   localparam logic [7:0] OFS_FREEZE_CH9_16   = 8'h0F;
   localparam logic [7:0] OFS_LEVEL_CH1_4     = 8'h10;
   localparam logic [7:0] OFS_LEVEL_CH5_8     = 8'h11;
   localparam logic [7:0] OFS_LEVEL_CH9_12    = 8'h12;
   localparam logic [7:0] OFS_LEVEL_CH13_16   = 8'h13;
   localparam logic [7:0] OFS_SENS_CH13_CH14  = 8'h22;
   localparam logic [7:0] OFS_SENS_CH15_CH16  = 8'h23;
   localparam logic [7:0] OFS_NOISE_LOCK      = 8'h3B;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_SENS            = 8'hBB;
   localparam logic [7:0] RST_GENERAL_CFG_A   = 8'h23;
   localparam logic [7:0] RST_GENERAL_CFG_B   = 8'h01;
   localparam logic [7:0] RST_LOW_BANK        = 8'hFE;
   localparam logic [7:0] RST_HIGH_BANK       = 8'hFF;
   localparam logic [7:0] RST_ZERO            = 8'h00;

   // ==========================================================
   // Field positions
   localparam int ODD_RANGE_BIT   = 3;
   localparam int ODD_CODE_LSB    = 0;
   localparam int EVEN_RANGE_BIT  = 7;
   localparam int EVEN_CODE_LSB   = 4;
   localparam int SPEED_MODE_BIT  = 7;
   localparam int FTW_LSB         = 5;
   localparam int IRQ_SEL_LSB     = 3;
   localparam int RESP_LSB        = 0;
   localparam int MULTI_BIT       = 5;
   localparam int IMP_SEL_BIT     = 4;
   localparam int SOFT_RESET_BIT  = 3;
   localparam int SLEEP_BIT       = 2;
   localparam logic [7:0] CFG_B_WMASK = 8'h3F;   // Bits 7:6 are reserved

   // ==========================================================
   // Touch level and interrupt level encodings
   localparam logic [1:0] LVL_NONE   = 2'h0;
   localparam logic [1:0] LVL_LOW    = 2'h1;
   localparam logic [1:0] LVL_MID    = 2'h2;
   localparam logic [1:0] LVL_HIGH   = 2'h3;
   localparam logic [1:0] IRQ_ON_MID_A = 2'h0;
   localparam logic [1:0] IRQ_ON_LOW   = 2'h1;
   localparam logic [1:0] IRQ_ON_MID_B = 2'h2;
   localparam logic [1:0] IRQ_ON_HIGH  = 2'h3;

   // ==========================================================
   // Response period offset and first-touch window
   localparam logic [3:0] RESP_OFFSET   = 4'h2;
   localparam int         FTW_UNIT      = 16;
   localparam logic [10:0] FTW_PERIODS_0 = 11'(19 * FTW_UNIT);
   localparam logic [10:0] FTW_PERIODS_1 = 11'(37 * FTW_UNIT);
   localparam logic [10:0] FTW_PERIODS_2 = 11'(56 * FTW_UNIT);
   localparam logic [10:0] FTW_PERIODS_3 = 11'(74 * FTW_UNIT);

   // ==========================================================
   // Thresholds in hundredths of a percent, indexed by the 3-bit code
   localparam logic [8:0] MID_TBL  [8] = '{9'h032, 9'h046, 9'h05A, 9'h078,
                                           9'h096, 9'h0CD, 9'h0FF, 9'h163};
   localparam logic [8:0] LOW_TBL  [8] = '{9'h028, 9'h037, 9'h046, 9'h05F,
                                           9'h078, 9'h0A0, 9'h0CD, 9'h11D};
   localparam logic [8:0] HIGH_TBL [8] = '{9'h03C, 9'h055, 9'h06E, 9'h091,
                                           9'h0B9, 9'h0F5, 9'h131, 9'h1AE};

endpackage

//--- logic/tsc_thresh_dec.sv
// Per-channel threshold decoder: middle and range-selected side threshold
module tsc_thresh_dec
   import tsc_pkg::*;
(
   input  wire logic [2:0] mid_thresh_code,   // Middle code of the channel
   input  wire logic       thresh_range_sel,  // 1 high table, 0 low table
   output wire logic [8:0] mid_thresh,        // Middle threshold, 0.01 %
   output wire logic [8:0] side_thresh        // Low or high threshold, 0.01 %
);

   // Monotonic middle table lookup
   assign mid_thresh  = MID_TBL[mid_thresh_code];
   // Range bit picks which side table the code indexes
   assign side_thresh = thresh_range_sel ? HIGH_TBL[mid_thresh_code]
                                         : LOW_TBL[mid_thresh_code];

endmodule

//--- sim/tsc_config_regs_sva.sv
// Port checks for the touch sensor register bank
module tsc_config_regs_sva
   import tsc_pkg::*;
#(
   parameter int CHANNELS      = 16, // Sensing channels
   parameter int PERIOD_CYCLES = 4   // Clock cycles per period
)(
   input wire logic                  clk,              // Clock
   input wire logic                  rstn,             // Reset, active low
   input wire logic [7:0]            reg_addr,         // Register address
   input wire logic                  reg_wr,           // Write strobe
   input wire logic [7:0]            reg_wdata,        // Write data
   input wire logic                  reg_rd,           // Read strobe
   input wire logic [7:0]            reg_rdata,        // Read data
   input wire logic [2*CHANNELS-1:0] touch_level_out,  // Registered levels
   input wire logic [9*CHANNELS-1:0] mid_thresh,       // Middle thresholds
   input wire logic [9*CHANNELS-1:0] side_thresh,      // Side thresholds
   input wire logic                  fast_calib,       // Fast calibration
   input wire logic                  first_touch_busy, // Window running
   input wire logic [3:0]            resp_period,      // Response period
   input wire logic                  soft_reset,       // Soft reset level
   input wire logic [2*CHANNELS-1:0] touch_level_in,   // Raw levels
   input wire logic                  irq               // Interrupt
);
   localparam int LO_C = (19 * 16 - 1) * PERIOD_CYCLES;
   localparam int HI_C = 74 * 16 * PERIOD_CYCLES + PERIOD_CYCLES + 4;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // ==========================================
   // Helpers: cycles since window start, any hard touch
   logic [15:0] win_cnt_q;
   logic        any_high;
   wire         all_none = (touch_level_out == '0);
   always_comb begin
      any_high = 1'b0;
      for (int i = 0; i < CHANNELS; i++) any_high |= (touch_level_out[2*i +: 2] == LVL_HIGH);
   end
   // Saturates so a stuck window cannot wrap back into range
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) win_cnt_q <= '0;
      else if (soft_reset) win_cnt_q <= '0;
      else if (win_cnt_q != 16'hFFFF) win_cnt_q <= win_cnt_q + 16'h1;
   end
   // ==========================================
   // Assertions
   level_copy_a: assert property (!$past(soft_reset) && !soft_reset |->
      touch_level_out == $past(touch_level_in)) else $error("level copy wrong");
   level_read_a: assert property (reg_rd && reg_addr == OFS_LEVEL_CH13_16 |=>
      reg_rdata == $past(touch_level_out[2*CHANNELS-1 -: 8])) else $error("level read wrong");
   irq_high_a: assert property (any_high && !soft_reset |=> irq)
      else $error("irq missing on hard touch");
   irq_idle_a: assert property (all_none |=> !irq) else $error("irq without touch");
   resp_write_a: assert property (reg_wr && reg_addr == OFS_GENERAL_CFG_A |=>
      resp_period == 4'($past(reg_wdata[2:0])) + 4'h2) else $error("response period wrong");
   speed_mode_a: assert property (reg_wr && reg_addr == OFS_GENERAL_CFG_A |=>
      fast_calib == ($past(reg_wdata[7]) | first_touch_busy)) else $error("speed mode wrong");
   odd_thresh_a: assert property (reg_wr && reg_addr == OFS_SENS_CH1_CH2 |=>
      mid_thresh[8:0] == MID_TBL[$past(reg_wdata[2:0])] && side_thresh[8:0] ==
      ($past(reg_wdata[3]) ? HIGH_TBL[$past(reg_wdata[2:0])] : LOW_TBL[$past(reg_wdata[2:0])]))
      else $error("odd channel threshold wrong");
   even_thresh_a: assert property (reg_wr && reg_addr == OFS_SENS_CH1_CH2 |=>
      mid_thresh[17:9] == MID_TBL[$past(reg_wdata[6:4])]) else $error("even threshold wrong");
   window_len_a: assert property ($fell(first_touch_busy) |->
      win_cnt_q >= LO_C && win_cnt_q <= HI_C) else $error("window length wrong");
   busy_fast_a: assert property (first_touch_busy |-> fast_calib)
      else $error("slow calibration in window");
endmodule

bind tsc_config_regs tsc_config_regs_sva #(
   .CHANNELS(CHANNELS), .PERIOD_CYCLES(PERIOD_CYCLES)
) u_tsc_config_regs_sva (
   .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .touch_level_out(touch_level_out), .mid_thresh(mid_thresh),
   .side_thresh(side_thresh), .fast_calib(fast_calib),
   .first_touch_busy(first_touch_busy), .resp_period(resp_period),
   .soft_reset(soft_reset), .touch_level_in(touch_level_in), .irq(irq)
);

//--- sim/tsc_host_model.sv
// Host model driving the register byte port
module tsc_host_model
   import tsc_pkg::*;
(
   input  wire logic       clk,       // Clock
   output logic      [7:0] reg_addr,  // Register address
   output logic            reg_wr,    // Write strobe
   output logic      [7:0] reg_wdata, // Write data
   output logic            reg_rd,    // Read strobe
   input  wire logic [7:0] reg_rdata  // Read data
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   // One-cycle write; reserved control bits always go out as zero
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = (a == OFS_GENERAL_CFG_B) ? (d & CFG_B_WMASK) : d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
   endtask
   // Read data is taken once the strobe edge has passed
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   task automatic init();
      write(OFS_GENERAL_CFG_B, 8'h03);
   endtask
endmodule

//--- sim/tsc_config_regs_bench.sv
// Self-checking bench for the touch sensor register bank
module tsc_config_regs_bench
   import tsc_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   localparam int P = 4;
   logic clk, rstn, fast_calib, busy, irq, soft_reset_bit;
   logic [7:0] addr, wdata, rdata, rd_v;
   logic wr, rd;
   logic [31:0] tin, tout;
   logic [143:0] mid, side;
   logic [3:0] resp;
   logic [1:0] ib;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   // Expected thresholds in hundredths of a percent
   logic [8:0] mt [8] = '{9'd50, 9'd70, 9'd90, 9'd120, 9'd150, 9'd205, 9'd255, 9'd355};
   logic [8:0] lt [8] = '{9'd40, 9'd55, 9'd70, 9'd95, 9'd120, 9'd160, 9'd205, 9'd285};
   logic [8:0] ht [8] = '{9'd60, 9'd85, 9'd110, 9'd145, 9'd185, 9'd245, 9'd305, 9'd430};
   logic [7:0] offs [22] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h22, 8'h23, 8'h08,
      8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h3B, 8'h10, 8'h11, 8'h12, 8'h13, 8'h01};
   logic [7:0] rstv [22] = '{8'hBB, 8'hBB, 8'hBB, 8'hBB, 8'hBB, 8'hBB, 8'hBB, 8'hBB, 8'h23,
      8'h01, 8'hFE, 8'hFF, 8'hFE, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   tsc_config_regs #(.CHANNELS(16), .PERIOD_CYCLES(P)) u_tsc_config_regs (
      .clk(clk), .rstn(rstn), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
      .reg_rd(rd), .reg_rdata(rdata), .touch_level_in(tin), .touch_level_out(tout),
      .mid_thresh(mid), .side_thresh(side), .fast_calib(fast_calib),
      .first_touch_busy(busy), .resp_period(resp), .multi_out_sel(), .imp_sel(),
      .sleep_en(), .soft_reset(soft_reset_bit), .init_bits(ib), .baseline_reload(),
      .channel_pause(), .calib_freeze(), .noise_lock(), .irq(irq));
   tsc_host_model u_tsc_host_model (.clk(clk), .reg_addr(addr), .reg_wr(wr),
      .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (fail_count == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Ceiling well above the sum of all windows
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         give_verdict();
      end
   end
   // Reset values over the whole map, unmapped address last
   task automatic t_reset_values();
      chk(16'(busy & fast_calib), 16'h1);
      for (int i = 0; i < 22; i++) begin
         u_tsc_host_model.read(offs[i], rd_v);
         chk(16'(rd_v), 16'(rstv[i]));
      end
   endtask
   // Write patterns; level registers and unmapped place must not take them
   task automatic t_readback();
      chk(16'(ib), 16'h3);
      for (int i = 0; i < 22; i++) begin
         u_tsc_host_model.write(offs[i], {4'(i), ~4'(i)});
         u_tsc_host_model.read(offs[i], rd_v);
         chk(16'(rd_v), (i == 9) ? 16'h0016 : (i > 16) ? 16'h0 : 16'({4'(i), ~4'(i)}));
      end
   endtask
   // Every code in both ranges, odd and even channel given opposite settings
   task automatic t_thresh();
      for (int c = 0; c < 8; c++) begin
         for (int r = 0; r < 2; r++) begin
            u_tsc_host_model.write(OFS_SENS_CH15_CH16, {1'(r), 3'(c), ~1'(r), ~3'(c)});
            chk(16'(mid[134:126]), 16'(mt[7-c]));
            chk(16'(side[134:126]), 16'(r ? lt[7-c] : ht[7-c]));
            chk(16'(mid[143:135]), 16'(mt[c]));
            chk(16'(side[143:135]), 16'(r ? ht[c] : lt[c]));
         end
      end
   endtask
   // Every interrupt level code against every touch level on the top channel
   task automatic t_irq();
      for (int s = 0; s < 4; s++) begin
         u_tsc_host_model.write(OFS_GENERAL_CFG_A, {3'b011, 2'(s), 3'b000});
         for (int l = 0; l < 4; l++) begin
            tin = {2'(l), 30'h0};
            repeat (3) @(posedge clk);
            #1;
            chk(16'(irq), 16'((s == 1) ? (l != 0) : (s == 3) ? (l == 3) : (l >= 2)));
            u_tsc_host_model.read(OFS_LEVEL_CH13_16, rd_v);
            chk(16'(rd_v), 16'({2'(l), 6'h0}));
         end
         tin = '0;
      end
   endtask
   // Every response code, fast mode forced
   task automatic t_resp();
      for (int v = 0; v < 8; v++) begin
         u_tsc_host_model.write(OFS_GENERAL_CFG_A, {3'b111, 2'b00, 3'(v)});
         chk(16'(resp), 16'(v + 2));
         chk(16'(fast_calib), 16'h1);
      end
   endtask
   // Each window code timed from the end of a soft reset
   task automatic t_window();
      int w [4] = '{19, 37, 56, 74};
      int n;
      for (int f = 0; f < 4; f++) begin
         u_tsc_host_model.write(OFS_GENERAL_CFG_A, {1'b0, 2'(f), 5'h0});
         u_tsc_host_model.write(OFS_GENERAL_CFG_B, 8'h0B);
         @(posedge clk);
         #1;
         chk(16'(soft_reset_bit), 16'h1);
         chk(16'(busy), 16'h1);
         u_tsc_host_model.write(OFS_GENERAL_CFG_B, 8'h03);
         n = 0;
         while (busy !== 1'b0 && n < 6000) begin
            @(posedge clk);
            #1;
            n++;
         end
         chk(16'(n >= (w[f] * 16 - 1) * P && n <= w[f] * 16 * P + P + 3), 16'h1);
         chk(16'(fast_calib), 16'h0);
      end
   endtask
   initial begin
      rstn = 1'b0;
      tin = '0;
      repeat (20) @(posedge clk);
      #1;
      rstn = 1'b1;
      t_reset_values();
      u_tsc_host_model.init();
      t_readback();
      t_thresh();
      t_irq();
      t_resp();
      t_window();
      give_verdict();
   end
endmodule
